// ### rtl/mcu_instruction_decoder.sv
// instruction decode and execute control of an 8-bit core
// assumes opcode and reg_rdata come from same-clock logic; reg_rdata
// answers reg_raddr combinationally; irq_req is a synchronous level
`timescale 1ns/1ps
module mcu_instruction_decoder #(
  parameter int PC_W = 11, // program counter width
  parameter int STACK_D = 8, // return stack depth
  parameter int SP_W = 3 // stack pointer width
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [12:0] opcode,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] ind_sel_reg,
  input wire logic irq_req,
  output logic [PC_W-1:0] pc,
  output logic [7:0] reg_raddr,
  output mcu_dec_pkg::reg_wr_t reg_wr,
  output logic [7:0] acc,
  output mcu_dec_pkg::flags_t flags,
  output logic gie,
  output logic to_flag,
  output logic pd_flag,
  output logic wdt_clear,
  output logic osc_stop
);
  // --------------------------------------------------------------
  // state
  // --------------------------------------------------------------
  mcu_dec_pkg::phase_t ph_ff, nxt_ph; // instruction cycle phase
  logic [PC_W-1:0] pc_ff, nxt_pc; // address of fetched word
  logic [7:0] a_ff, nxt_a; // accumulator
  mcu_dec_pkg::flags_t fl_ff, nxt_fl; // status flags
  logic gie_ff, nxt_gie; // global interrupt enable
  logic [4:0] page_ff, nxt_page; // page bits
  logic stall_ff, nxt_stall; // idle cycle after pc reload
  logic flush_ff, nxt_flush; // discard skipped word
  logic [SP_W-1:0] sp_ff, nxt_sp; // stack pointer
  logic [PC_W-1:0] stk_ff [STACK_D]; // return stack
  logic [7:0] raddr_ff, nxt_raddr; // read address
  mcu_dec_pkg::reg_wr_t wr_ff, nxt_wr; // write strobe
  logic to_ff, nxt_to, pd_ff, nxt_pd, wdc_ff, nxt_wdc;
  logic push; // stack write this edge
  logic [PC_W-1:0] push_val;
  logic exec_go; // an instruction executes now

  // add with carry in, returns {c, nibble carry, sum}
  function automatic logic [9:0] addc(input logic [7:0] x, input logic [7:0] y,
                                      input logic ci);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, x} + {1'b0, y} + {8'h00, ci};
    n = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
    return {s[8], n[4], s[7:0]};
  endfunction

  // --------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------
  always_comb begin
    logic [7:0] r, res;
    logic [9:0] sum;
    logic [PC_W-1:0] pc1, tgt, top;
    logic wr_a, wr_r, upd_z, upd_cdc, skip, stall;
    r = reg_rdata;
    res = 8'h00;
    sum = addc(a_ff, 8'h00, 1'b0);
    pc1 = pc_ff + {{(PC_W-1){1'b0}}, 1'b1};
    tgt = {page_ff[PC_W-11:0], opcode[9:0]};
    top = stk_ff[sp_ff - {{(SP_W-1){1'b0}}, 1'b1}];
    wr_a = 1'b0;
    wr_r = 1'b0;
    upd_z = 1'b0;
    upd_cdc = 1'b0;
    skip = 1'b0;
    stall = 1'b0;
    nxt_ph = ph_ff;
    nxt_pc = pc_ff;
    nxt_a = a_ff;
    nxt_fl = fl_ff;
    nxt_gie = gie_ff;
    nxt_page = page_ff;
    nxt_stall = stall_ff;
    nxt_flush = flush_ff;
    nxt_sp = sp_ff;
    nxt_raddr = raddr_ff;
    nxt_wr = '0;
    nxt_to = to_ff;
    nxt_pd = pd_ff;
    nxt_wdc = 1'b0;
    push = 1'b0;
    push_val = pc1;
    exec_go = 1'b0;
    if (ce) begin
      unique case (ph_ff)
        // first clock: latch bank-qualified register address
        mcu_dec_pkg::PH_FETCH: begin
          nxt_raddr = {ind_sel_reg[mcu_dec_pkg::BANK_MSB:mcu_dec_pkg::BANK_LSB],
                       opcode[mcu_dec_pkg::REG_MSB:mcu_dec_pkg::REG_LSB]};
          nxt_ph = mcu_dec_pkg::PH_EXEC;
        end
        // second clock: execute
        mcu_dec_pkg::PH_EXEC: begin
          nxt_ph = mcu_dec_pkg::PH_FETCH;
          if (stall_ff) begin
            nxt_stall = 1'b0; // second cycle of a reload, pc held
          end else if (flush_ff) begin
            nxt_flush = 1'b0; // skipped word discarded
            nxt_pc = pc1;
          end else if (irq_req && gie_ff) begin
            push = 1'b1; // current word is re-fetched on return
            push_val = pc_ff;
            nxt_sp = sp_ff + {{(SP_W-1){1'b0}}, 1'b1};
            nxt_pc = mcu_dec_pkg::VEC_IRQ[PC_W-1:0];
            nxt_gie = 1'b0;
            nxt_stall = 1'b1;
          end else begin
            exec_go = 1'b1;
            nxt_pc = pc1;
            priority casez (opcode)
              mcu_dec_pkg::OP_SLEEP: begin
                nxt_wdc = 1'b1;
                nxt_to = 1'b1;
                nxt_pd = 1'b0;
                nxt_ph = mcu_dec_pkg::PH_SLEEP;
              end
              mcu_dec_pkg::OP_WDOG_CLR: begin
                nxt_wdc = 1'b1;
                nxt_to = 1'b1;
                nxt_pd = 1'b1;
              end
              mcu_dec_pkg::OP_INT_EN: nxt_gie = 1'b1;
              mcu_dec_pkg::OP_INT_DIS: nxt_gie = 1'b0;
              mcu_dec_pkg::OP_RET, mcu_dec_pkg::OP_RET_INT: begin
                nxt_pc = top;
                nxt_sp = sp_ff - {{(SP_W-1){1'b0}}, 1'b1};
                stall = 1'b1;
                if (opcode[0]) nxt_gie = 1'b1;
              end
              mcu_dec_pkg::OP_TABLE: begin
                sum = addc(pc1[7:0], a_ff, 1'b0);
                res = sum[7:0];
                nxt_pc = {pc1[PC_W-1:8], sum[7:0]};
                upd_z = 1'b1;
                upd_cdc = 1'b1;
                stall = 1'b1;
              end
              mcu_dec_pkg::OP_CLRA: begin
                wr_a = 1'b1;
                upd_z = 1'b1;
              end
              mcu_dec_pkg::OP_INT: begin
                push = 1'b1;
                nxt_sp = sp_ff + {{(SP_W-1){1'b0}}, 1'b1};
                nxt_pc = mcu_dec_pkg::VEC_SWI[PC_W-1:0];
              end
              13'b0_0000_01??_????: begin
                res = a_ff; // move A to register
                wr_r = 1'b1;
              end
              13'b0_0000_11??_????: begin
                wr_r = 1'b1; // clear register
                upd_z = 1'b1;
              end
              13'b0_0???_????_????: begin
                wr_a = ~opcode[6];
                wr_r = opcode[6];
                upd_z = 1'b1;
                unique case (opcode[10:7])
                  4'h2: begin
                    sum = addc(r, ~a_ff, 1'b1); // R - A
                    res = sum[7:0];
                    upd_cdc = 1'b1;
                  end
                  4'h3: res = r - 8'h01;
                  4'h4: res = a_ff | r;
                  4'h5: res = a_ff & r;
                  4'h6: res = a_ff ^ r;
                  4'h7: begin
                    sum = addc(a_ff, r, 1'b0);
                    res = sum[7:0];
                    upd_cdc = 1'b1;
                  end
                  4'h8: res = r;
                  4'h9: res = ~r;
                  4'hA: res = r + 8'h01;
                  4'hB, 4'hF: begin
                    res = opcode[10:7] == 4'hB ? r - 8'h01 : r + 8'h01;
                    skip = res == 8'h00;
                    upd_z = 1'b0;
                  end
                  4'hC, 4'hD: begin
                    res = opcode[7] ? {r[6:0], fl_ff.c} : {fl_ff.c, r[7:1]};
                    nxt_fl.c = opcode[7] ? r[7] : r[0];
                    upd_z = 1'b0;
                  end
                  4'hE: begin
                    res = {r[3:0], r[7:4]};
                    upd_z = 1'b0;
                  end
                  default: begin
                    wr_a = 1'b0; // unsupported group-zero codes
                    wr_r = 1'b0;
                    upd_z = 1'b0;
                  end
                endcase
              end
              13'b0_1???_????_????: begin
                res = r;
                res[opcode[mcu_dec_pkg::BIT_MSB:mcu_dec_pkg::BIT_LSB]] = opcode[9];
                wr_r = ~opcode[10];
                skip = opcode[10] &&
                       (r[opcode[mcu_dec_pkg::BIT_MSB:mcu_dec_pkg::BIT_LSB]] == opcode[9]);
              end
              13'b1_00??_????_????, 13'b1_01??_????_????: begin
                push = ~opcode[10];
                if (!opcode[10]) nxt_sp = sp_ff + {{(SP_W-1){1'b0}}, 1'b1};
                nxt_pc = tgt;
                stall = 1'b1;
              end
              13'b1_1000_????_????: begin
                res = opcode[7:0];
                wr_a = 1'b1;
              end
              13'b1_1001_????_????, 13'b1_1010_????_????, 13'b1_1011_????_????: begin
                res = opcode[9:8] == 2'b01 ? a_ff | opcode[7:0] :
                      opcode[9:8] == 2'b10 ? a_ff & opcode[7:0] : a_ff ^ opcode[7:0];
                wr_a = 1'b1;
                upd_z = 1'b1;
              end
              13'b1_1100_????_????: begin
                res = opcode[7:0];
                wr_a = 1'b1;
                nxt_pc = top;
                nxt_sp = sp_ff - {{(SP_W-1){1'b0}}, 1'b1};
                stall = 1'b1;
              end
              13'b1_1101_????_????, 13'b1_1111_????_????: begin
                sum = opcode[9] ? addc(opcode[7:0], a_ff, 1'b0) :
                      addc(opcode[7:0], ~a_ff, 1'b1);
                res = sum[7:0];
                wr_a = 1'b1;
                upd_z = 1'b1;
                upd_cdc = 1'b1;
              end
              13'b1_1110_100?_????: nxt_page = opcode[4:0];
              default: ; // undefined encodings do nothing
            endcase
            if (wr_a) nxt_a = res;
            if (wr_r) nxt_wr = '{we: 1'b1, addr: raddr_ff, data: res};
            if (upd_z) nxt_fl.z = res == 8'h00;
            if (upd_cdc) begin
              nxt_fl.c = sum[9];
              nxt_fl.digit_carry_flag = sum[8];
            end
            nxt_flush = skip;
            nxt_stall = stall;
          end
        end
        mcu_dec_pkg::PH_SLEEP: ; // oscillator stopped until reset
        default: nxt_ph = mcu_dec_pkg::PH_FETCH;
      endcase
    end
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ph_ff <= mcu_dec_pkg::PH_FETCH;
      pc_ff <= mcu_dec_pkg::VEC_RESET[PC_W-1:0];
      a_ff <= mcu_dec_pkg::ACC_RST;
      fl_ff <= '0;
      gie_ff <= mcu_dec_pkg::GIE_RST;
      page_ff <= mcu_dec_pkg::PAGE_RST;
      stall_ff <= 1'b0;
      flush_ff <= 1'b0;
      sp_ff <= '0;
      raddr_ff <= 8'h00;
      wr_ff <= '0;
      to_ff <= mcu_dec_pkg::TO_RST;
      pd_ff <= mcu_dec_pkg::PD_RST;
      wdc_ff <= 1'b0;
    end else begin
      ph_ff <= nxt_ph;
      pc_ff <= nxt_pc;
      a_ff <= nxt_a;
      fl_ff <= nxt_fl;
      gie_ff <= nxt_gie;
      page_ff <= nxt_page;
      stall_ff <= nxt_stall;
      flush_ff <= nxt_flush;
      sp_ff <= nxt_sp;
      raddr_ff <= nxt_raddr;
      wr_ff <= nxt_wr;
      to_ff <= nxt_to;
      pd_ff <= nxt_pd;
      wdc_ff <= nxt_wdc;
    end
  end

  // return stack storage, no reset needed
  always_ff @(posedge clk) begin
    if (push) stk_ff[sp_ff] <= push_val;
  end

  // outputs straight from flops, except osc_stop, decoded from the phase flops
  assign pc = pc_ff;
  assign reg_raddr = raddr_ff;
  assign reg_wr = wr_ff;
  assign acc = a_ff;
  assign flags = fl_ff;
  assign gie = gie_ff;
  assign to_flag = to_ff;
  assign pd_flag = pd_ff;
  assign wdt_clear = wdc_ff;
  assign osc_stop = ph_ff == mcu_dec_pkg::PH_SLEEP;

  // --------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);
  sequence s_reload; stall_ff ##1 stall_ff ##1 !stall_ff; endsequence
  sequence s_jump; exec_go && opcode[12:11] == 2'b10; endsequence
  property p_phase; ph_ff == mcu_dec_pkg::PH_FETCH |=> ph_ff == mcu_dec_pkg::PH_EXEC; endproperty
  a_phase: assert property (p_phase) else $error("fetch not followed by exec");
  property p_jump; s_jump |=> pc_ff == $past({page_ff[PC_W-11:0], opcode[9:0]}) ##0 s_reload;
  endproperty
  a_jump: assert property (p_jump) else $error("jump target or timing wrong");
  property p_bank; ph_ff == mcu_dec_pkg::PH_FETCH |=> reg_raddr[7:6] == $past(ind_sel_reg[7:6]);
  endproperty
  a_bank: assert property (p_bank) else $error("bank bits not applied");
  property p_irq; ph_ff == mcu_dec_pkg::PH_EXEC && !stall_ff && !flush_ff && irq_req && gie_ff
    |=> pc_ff == mcu_dec_pkg::VEC_IRQ[PC_W-1:0] && !gie_ff; endproperty
  a_irq: assert property (p_irq) else $error("interrupt vector not taken");
  property p_int_en; exec_go && opcode == mcu_dec_pkg::OP_INT_EN |=> gie_ff; endproperty
  a_int_en: assert property (p_int_en) else $error("enable not applied");
  property p_sleep; exec_go && opcode == mcu_dec_pkg::OP_SLEEP
    |=> wdt_clear && osc_stop && !pd_flag && to_flag; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep effects missing");
  property p_lit_ret; exec_go && opcode[12:8] == 5'h1C
    |=> acc == $past(opcode[7:0]) ##0 s_reload; endproperty
  a_lit_ret: assert property (p_lit_ret) else $error("literal return wrong");
  logic skip_bit; // expected outcome of a bit test
  assign skip_bit = reg_rdata[opcode[8:6]] == opcode[9];
  // a taken skip must clear after its discard cycle; a following skip may set it again
  property p_skip; exec_go && opcode[12:10] == 3'b011
    |=> flush_ff == $past(skip_bit) ##2 !(flush_ff && $past(flush_ff, 2)); endproperty
  a_skip: assert property (p_skip) else $error("bit test skip wrong");
  property p_clr; exec_go && opcode[12:6] == 7'h03 |=> reg_wr.we && reg_wr.data == 8'h00 && flags.z;
  endproperty
  a_clr: assert property (p_clr) else $error("clear did not set zero");
endmodule // mcu_instruction_decoder

// ### rtl/mcu_dec_pkg.sv
// package: constants and types shared by the instruction decoder
// assumes a single clock domain; no module of its own
package mcu_dec_pkg;
  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000; // main clock rate
  localparam int CLKS_PER_CYCLE = 2; // main clocks per instruction cycle
  // --------------------------------------------------------------
  // opcode fields and vectors
  // --------------------------------------------------------------
  localparam int REG_LSB = 0; // register designator, 6 bits
  localparam int REG_MSB = 5;
  localparam int BIT_LSB = 6; // bit designator, 3 bits
  localparam int BIT_MSB = 8;
  localparam int BANK_LSB = 6; // bank bits of indirect select register
  localparam int BANK_MSB = 7;
  localparam logic [10:0] VEC_RESET = 11'h000;
  localparam logic [10:0] VEC_IRQ = 11'h008;
  localparam logic [10:0] VEC_SWI = 11'h001;
  // --------------------------------------------------------------
  // fixed opcode words
  // --------------------------------------------------------------
  localparam logic [12:0] OP_SLEEP = 13'h0003;
  localparam logic [12:0] OP_WDOG_CLR = 13'h0004;
  localparam logic [12:0] OP_INT_EN = 13'h0010;
  localparam logic [12:0] OP_INT_DIS = 13'h0011;
  localparam logic [12:0] OP_RET = 13'h0012;
  localparam logic [12:0] OP_RET_INT = 13'h0013;
  localparam logic [12:0] OP_TABLE = 13'h0020;
  localparam logic [12:0] OP_CLRA = 13'h0080;
  localparam logic [12:0] OP_INT = 13'h1E01;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] PAGE_RST = 5'h00;
  localparam logic GIE_RST = 1'b0;
  localparam logic TO_RST = 1'b1;
  localparam logic PD_RST = 1'b1;
  // --------------------------------------------------------------
  // types
  // --------------------------------------------------------------
  typedef struct packed {
    logic z; // zero
    logic c; // carry
    logic digit_carry_flag; // carry out of the low nibble
  } flags_t;
  typedef struct packed {
    logic we; // one-cycle write strobe
    logic [7:0] addr; // {bank, designator}
    logic [7:0] data;
  } reg_wr_t;
  typedef enum logic [1:0] {
    PH_FETCH = 2'b00,
    PH_EXEC = 2'b01,
    PH_SLEEP = 2'b11
  } phase_t;
endpackage

// ### bench/prog_reg_model.sv
// program memory and register file standing around the decoder
// assumes one clock; the bench loads rom and rf by hierarchical access
`timescale 1ns/1ps
module prog_reg_model (
  input wire logic clk,
  input wire logic [10:0] pc,
  input wire logic [7:0] reg_raddr,
  input wire mcu_dec_pkg::reg_wr_t reg_wr,
  output logic [12:0] opcode,
  output logic [7:0] reg_rdata
);
  // --------------------------------------------------------------
  // storage
  // --------------------------------------------------------------
  logic [12:0] rom [0:2047]; // program words
  logic [7:0] rf [0:255]; // {bank, designator} addressed registers
  // combinational answers, same clock
  assign opcode = rom[pc];
  assign reg_rdata = rf[reg_raddr];
  // register write on the one-cycle strobe
  always @(posedge clk) begin
    if (reg_wr.we === 1'b1) begin
      rf[reg_wr.addr] <= reg_wr.data;
    end
  end
endmodule // prog_reg_model

// ### bench/mcu_instruction_decoder_tb.sv
// self-checking bench: runs short programs and checks the results
// assumes the partner model holds program and registers
`timescale 1ns/1ps
module mcu_instruction_decoder_tb;
  // --------------------------------------------------------------
  // signals
  // --------------------------------------------------------------
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1; // run enable
  logic [7:0] ind_sel_reg = 8'h00; // bank select source
  logic irq_req = 1'b0; // interrupt request level
  logic [12:0] opcode;
  logic [7:0] reg_rdata;
  logic [10:0] pc;
  logic [7:0] reg_raddr;
  mcu_dec_pkg::reg_wr_t reg_wr;
  logic [7:0] acc;
  mcu_dec_pkg::flags_t flags;
  logic gie, to_flag, pd_flag, wdt_clear, osc_stop;
  int failures = 0; // mismatch count
  int checks = 0; // comparison count
  int wdt_cnt = 0; // watchdog clear pulses seen
  logic [10:0] held_pc; // pc snapshot
  // 20 MHz clock
  always #25 clk = ~clk;
  // --------------------------------------------------------------
  // instances
  // --------------------------------------------------------------
  mcu_instruction_decoder dut (.clk(clk), .rstn(rstn), .ce(ce), .opcode(opcode),
    .reg_rdata(reg_rdata), .ind_sel_reg(ind_sel_reg), .irq_req(irq_req), .pc(pc),
    .reg_raddr(reg_raddr), .reg_wr(reg_wr), .acc(acc), .flags(flags), .gie(gie),
    .to_flag(to_flag), .pd_flag(pd_flag), .wdt_clear(wdt_clear), .osc_stop(osc_stop));
  prog_reg_model pm (.clk(clk), .pc(pc), .reg_raddr(reg_raddr), .reg_wr(reg_wr),
    .opcode(opcode), .reg_rdata(reg_rdata));
  // counts one-cycle watchdog clear pulses
  always @(posedge clk) begin
    if (wdt_clear === 1'b1) begin
      wdt_cnt++;
    end
  end
  // --------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------
  // compare and report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    if (failures == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // reset with empty memory, then bank select, then reset values
  task automatic do_reset(input logic [7:0] sel);
    rstn <= 1'b0;
    ind_sel_reg <= sel;
    irq_req <= 1'b0;
    ce <= 1'b1;
    wdt_cnt = 0;
    for (int i = 0; i < 2048; i++) pm.rom[i] = 13'h0000;
    for (int i = 0; i < 256; i++) pm.rf[i] = 8'h00;
    repeat (10) @(posedge clk);
    check({5'h0, pc}, 16'h0000);
    check({8'h0, acc}, 16'h0000);
    check({13'h0, flags}, 16'h0000);
    check({12'h0, gie, to_flag, pd_flag, osc_stop}, 16'h0006);
    check({15'h0, reg_wr.we}, 16'h0000);
  endtask
  // start the program
  task automatic release_reset();
    rstn <= 1'b1;
  endtask
  // wait for pc to reach an address, bounded, then let results land
  task automatic wait_pc(input logic [10:0] addr);
    int n;
    n = 0;
    while (pc !== addr && n < 200) begin
      @(posedge clk);
      n++;
    end
    if (n >= 200) begin
      check({5'h0, pc}, {5'h0, addr});
    end
    repeat (6) @(posedge clk);
  endtask
  // --------------------------------------------------------------
  // tests
  // --------------------------------------------------------------
  initial begin
    // add immediate, register write in bank 1, bit set, bit skip, subtract
    do_reset(8'h40);
    pm.rom[0] = 13'h18F0;
    pm.rom[1] = 13'h1F20;
    pm.rom[2] = 13'h0060;
    pm.rom[3] = 13'h0A20;
    pm.rom[4] = 13'h0F20;
    pm.rom[5] = 13'h18AA;
    pm.rom[6] = 13'h1D11;
    pm.rom[7] = 13'h1407;
    ce <= 1'b0;
    release_reset();
    repeat (6) @(posedge clk);
    check({5'h0, pc}, 16'h0000);
    ce <= 1'b1;
    wait_pc(11'h007);
    check({8'h0, pm.rf[8'h60]}, 16'h0011);
    check({8'h0, acc}, 16'h0001);
    check({13'h0, flags}, 16'h0003);
    // call with literal return, rotates through carry, zero result, bank 2
    do_reset(8'h80);
    pm.rom[0] = 13'h1804;
    pm.rom[1] = 13'h1005;
    pm.rom[2] = 13'h0060;
    pm.rom[3] = 13'h0660;
    pm.rom[4] = 13'h1406;
    pm.rom[5] = 13'h1C81;
    pm.rom[6] = 13'h06A0;
    pm.rom[7] = 13'h1D81;
    pm.rom[8] = 13'h1408;
    release_reset();
    wait_pc(11'h008);
    check({8'h0, pm.rf[8'hA0]}, 16'h0040);
    check({8'h0, pm.rf[8'h60]}, 16'h0000);
    check({8'h0, acc}, 16'h0000);
    check({13'h0, flags}, 16'h0007);
    // interrupt entry to the vector and return
    do_reset(8'h00);
    pm.rom[0] = 13'h0010;
    pm.rom[1] = 13'h1401;
    pm.rom[8] = 13'h0013;
    release_reset();
    wait_pc(11'h001);
    check({15'h0, gie}, 16'h0001);
    irq_req <= 1'b1;
    // drop the request in the entry cycle, before the return re-arms it
    wait (pc === 11'h008);
    @(posedge clk);
    irq_req <= 1'b0;
    check({5'h0, pc}, 16'h0008);
    check({15'h0, gie}, 16'h0000);
    wait_pc(11'h001);
    check({15'h0, gie}, 16'h0001);
    // table read, disable, watchdog clear, sleep freeze
    do_reset(8'h00);
    pm.rom[0] = 13'h0010;
    pm.rom[1] = 13'h0011;
    pm.rom[2] = 13'h1802;
    pm.rom[3] = 13'h0020;
    pm.rom[4] = 13'h18EE;
    pm.rom[5] = 13'h18EE;
    pm.rom[6] = 13'h0004;
    pm.rom[7] = 13'h0003;
    release_reset();
    wait_pc(11'h007);
    check({8'h0, acc}, 16'h0002);
    check({13'h0, flags}, 16'h0000);
    check({15'h0, gie}, 16'h0000);
    check({13'h0, to_flag, pd_flag, osc_stop}, 16'h0005);
    check(wdt_cnt[15:0], 16'h0002);
    held_pc = pc;
    repeat (8) @(posedge clk);
    check({5'h0, pc}, {5'h0, held_pc});
    // wake by reset, page bit, clear, software vector, return, count skips
    do_reset(8'h00);
    pm.rom[0] = 13'h1402;
    pm.rom[1] = 13'h0012;
    pm.rom[2] = 13'h1E81;
    pm.rom[3] = 13'h1403;
    pm.rom[11'h403] = 13'h00D0;
    pm.rom[11'h404] = 13'h1E01;
    pm.rom[11'h405] = 13'h05D0;
    pm.rom[11'h406] = 13'h07D0;
    pm.rom[11'h407] = 13'h18AA;
    pm.rom[11'h408] = 13'h1B3C;
    pm.rom[11'h409] = 13'h1409;
    pm.rf[8'h10] = 8'h5A;
    release_reset();
    wait_pc(11'h409);
    check({5'h0, pc}, 16'h0409);
    check({8'h0, pm.rf[8'h10]}, 16'h0000);
    check({8'h0, acc}, 16'h003C);
    check({13'h0, flags}, 16'h0000);
    stop_test();
  end
  // cuts a hang short
  initial begin
    #1000000;
    failures++;
    stop_test();
  end
endmodule // mcu_instruction_decoder_tb
